// [shared/fwg_pkg.sv]
`default_nettype none
package fwg_pkg;
  // register byte offsets
  localparam logic [7:0] FWG_OFF_CMD = 8'h00;
  localparam logic [7:0] FWG_OFF_ADDR = 8'h04;
  localparam logic [7:0] FWG_OFF_STAT = 8'h08;
  localparam logic [7:0] FWG_OFF_PROT_LO = 8'h10;
  localparam logic [7:0] FWG_OFF_PROT_HI = 8'h14;
  // command register fields
  localparam int FWG_CMD_LSB = 0;
  localparam int FWG_CMD_W = 3;
  localparam int FWG_BP_PAY_LSB = 8;
  // status register fields
  localparam int FWG_ST_BUSY = 0;
  localparam int FWG_ST_LATCH = 1;
  localparam int FWG_ST_READY = 2;
  localparam int FWG_ST_INHIBIT = 3;
  localparam int FWG_ST_REFUSED = 4;
  localparam int FWG_ST_BP_LSB = 8;
  // geometry
  localparam int FWG_ADDR_W = 24;
  localparam int FWG_SECT_LSB = 12;
  localparam int FWG_SECT_MAX = 64;
  localparam int FWG_BLK_SECT = 16;
  localparam int FWG_CNT_W = 20;
  // reset values
  localparam logic [63:0] FWG_PROT_RST = 64'hFFFFFFFFFFFFFFFF;
  localparam logic [2:0] FWG_BP_RST = 3'h0;
  localparam logic [23:0] FWG_ADDR_RST = 24'h000000;
  // timing
  localparam int FWG_CLK_HZ = 100_000_000;
  localparam int FWG_PUW_MS = 1;
  localparam int FWG_ERASE_MAX_MS = 10;
  localparam int FWG_PROG_TYP_MS = 2;
  localparam int FWG_PROG_MAX_MS = 5;
  localparam int FWG_PUW_CYC = FWG_PUW_MS * (FWG_CLK_HZ / 1000);
  localparam int FWG_ERASE_CYC = FWG_ERASE_MAX_MS * (FWG_CLK_HZ / 1000);
  localparam int FWG_PROG_CYC = FWG_PROG_TYP_MS * (FWG_CLK_HZ / 1000);
  localparam int FWG_PROG_MAX_CYC = FWG_PROG_MAX_MS * (FWG_CLK_HZ / 1000);

  typedef enum logic [2:0] {
    FWG_CMD_NONE = 3'h0,
    FWG_CMD_PERMIT = 3'h1,
    FWG_CMD_FORBID = 3'h2,
    FWG_CMD_SECT_ERASE = 3'h3,
    FWG_CMD_BLOCK_ERASE = 3'h4,
    FWG_CMD_CHIP_ERASE = 3'h5,
    FWG_CMD_PROGRAM = 3'h6,
    FWG_CMD_STATUS_WR = 3'h7
  } fwg_cmd_t;

  typedef enum logic [1:0] {
    FWG_ST_POWERUP = 2'b00,
    FWG_ST_STANDBY = 2'b01,
    FWG_ST_ERASE = 2'b10,
    FWG_ST_PROGRAM = 2'b11
  } fwg_state_t;
endpackage
`default_nettype wire

// [hw/fwg_guard.sv]
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module fwg_guard import fwg_pkg::*; #(
  parameter int NSECT = 64,
  parameter int PUW_CYC = FWG_PUW_CYC,
  parameter int ERASE_CYC = FWG_ERASE_CYC,
  parameter int PROG_CYC = FWG_PROG_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_low,
  output logic busy,
  output logic write_latch_flag,
  output logic dev_ready,
  output logic op_done
);
  localparam int SBITS = $clog2(NSECT);

  fwg_state_t st_ff, nxt_st;
  logic [FWG_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic latch_ff, nxt_latch;
  logic [2:0] bp_ff, nxt_bp;
  logic refused_ff, nxt_refused;
  logic done_ff, nxt_done;
  logic busy_ff, ready_ff;
  logic [FWG_ADDR_W-1:0] tgt_ff;
  logic [63:0] prot_ff;
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;

  // bus decode
  wire setup_ph = psel & ~penable;
  wire acc_go = psel & penable & pready_ff;
  wire wr_go = acc_go & pwrite;
  wire sel_cmd = (paddr == FWG_OFF_CMD);
  wire sel_addr = (paddr == FWG_OFF_ADDR);
  wire sel_stat = (paddr == FWG_OFF_STAT);
  wire sel_prot_lo = (paddr == FWG_OFF_PROT_LO);
  wire sel_prot_hi = (paddr == FWG_OFF_PROT_HI);
  wire mapped = sel_cmd | sel_addr | sel_stat | sel_prot_lo | sel_prot_hi;
  wire cmd_go = wr_go & sel_cmd;
  wire fwg_cmd_t cmd_code = fwg_cmd_t'(pwdata[FWG_CMD_LSB +: FWG_CMD_W]);
  wire [2:0] bp_pay = pwdata[FWG_BP_PAY_LSB +: 3];

  // protection decode on address bits above the 4KB offset
  wire [5:0] sect_idx = 6'(tgt_ff[FWG_SECT_LSB +: SBITS]);
  wire [5:0] blk_base = {sect_idx[5:4], 4'h0};
  wire [63:0] prot_used = prot_ff | ~(64'hFFFFFFFFFFFFFFFF >> (FWG_SECT_MAX - NSECT));
  wire sect_ok = prot_ff[sect_idx];
  wire blk_ok = &prot_used[blk_base +: FWG_BLK_SECT];
  wire chip_ok = (&prot_used) & (bp_ff == FWG_BP_RST);
  wire is_sect = (cmd_code == FWG_CMD_SECT_ERASE);
  wire is_blk = (cmd_code == FWG_CMD_BLOCK_ERASE);
  wire is_chip = (cmd_code == FWG_CMD_CHIP_ERASE);
  wire is_prog = (cmd_code == FWG_CMD_PROGRAM);
  wire is_erase = is_sect | is_blk | is_chip;
  wire perm_ok = is_chip ? chip_ok : (is_blk ? blk_ok : sect_ok);
  wire standby = (st_ff == FWG_ST_STANDBY) & ~supply_low;
  wire start_ok = cmd_go & standby & latch_ff & (is_erase | is_prog) & perm_ok;
  wire prot_wr_ok = standby;

  wire [31:0] stat_word = {21'h000000, bp_ff, 3'h0, refused_ff, supply_low, ready_ff, latch_ff, busy_ff};
  wire [31:0] rd_mux = sel_cmd ? 32'h00000000 :
                       sel_addr ? {8'h00, tgt_ff} :
                       sel_stat ? stat_word :
                       sel_prot_lo ? prot_ff[31:0] :
                       sel_prot_hi ? prot_ff[63:32] : 32'h00000000;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff + 20'h00001;
    nxt_latch = latch_ff;
    nxt_bp = bp_ff;
    nxt_refused = refused_ff;
    nxt_done = 1'b0;
    case (st_ff)
      FWG_ST_POWERUP: begin
        if (cnt_ff == 20'(PUW_CYC - 1)) begin
          nxt_st = FWG_ST_STANDBY;
          nxt_cnt = 20'h00000;
          nxt_latch = 1'b0;
        end
      end
      FWG_ST_STANDBY: begin
        nxt_cnt = 20'h00000;
        if (cmd_go) begin
          nxt_refused = 1'b0;
          if (cmd_code == FWG_CMD_PERMIT) begin
            nxt_latch = 1'b1;
          end else if (cmd_code == FWG_CMD_FORBID) begin
            nxt_latch = 1'b0;
          end else if (cmd_code == FWG_CMD_STATUS_WR) begin
            if (latch_ff) begin
              nxt_bp = bp_pay;
              nxt_latch = 1'b0;
              nxt_done = 1'b1;
            end else begin
              nxt_refused = 1'b1;
            end
          end else if (start_ok) begin
            nxt_st = is_prog ? FWG_ST_PROGRAM : FWG_ST_ERASE;
          end else if (is_erase | is_prog) begin
            nxt_refused = 1'b1;
          end
        end
      end
      FWG_ST_ERASE: begin
        if (cmd_go) begin
          nxt_refused = 1'b1;
        end
        if (cnt_ff == 20'(ERASE_CYC - 1)) begin
          nxt_st = FWG_ST_STANDBY;
          nxt_cnt = 20'h00000;
          nxt_latch = 1'b0;
          nxt_done = 1'b1;
        end
      end
      default: begin
        if (cmd_go) begin
          nxt_refused = 1'b1;
        end
        if (cnt_ff == 20'(PROG_CYC - 1)) begin
          nxt_st = FWG_ST_STANDBY;
          nxt_cnt = 20'h00000;
          nxt_latch = 1'b0;
          nxt_done = 1'b1;
        end
      end
    endcase
  end

  // core state; low supply acts as a synchronous reset of all of it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= FWG_ST_POWERUP;
      cnt_ff <= 20'h00000;
      latch_ff <= 1'b0;
      bp_ff <= FWG_BP_RST;
      refused_ff <= 1'b0;
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else if (supply_low) begin
      st_ff <= FWG_ST_POWERUP;
      cnt_ff <= 20'h00000;
      latch_ff <= 1'b0;
      bp_ff <= FWG_BP_RST;
      refused_ff <= 1'b0;
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      latch_ff <= nxt_latch;
      bp_ff <= nxt_bp;
      refused_ff <= nxt_refused;
      done_ff <= nxt_done;
      busy_ff <= (nxt_st == FWG_ST_ERASE) | (nxt_st == FWG_ST_PROGRAM);
      ready_ff <= (nxt_st != FWG_ST_POWERUP);
    end
  end

  // protection bits and target address, kept through supply dips
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prot_ff <= FWG_PROT_RST;
      tgt_ff <= FWG_ADDR_RST;
    end else begin
      if (wr_go & sel_prot_lo & prot_wr_ok) begin
        prot_ff[31:0] <= pwdata;
      end
      if (wr_go & sel_prot_hi & prot_wr_ok) begin
        prot_ff[63:32] <= pwdata;
      end
      if (wr_go & sel_addr) begin
        tgt_ff <= pwdata[FWG_ADDR_W-1:0];
      end
    end
  end

  // apb answer: ready in the first access cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= setup_ph;
      pslverr_ff <= setup_ph & ~mapped;
      prdata_ff <= (setup_ph & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign busy = busy_ff;
  assign write_latch_flag = latch_ff;
  assign dev_ready = ready_ff;
  assign op_done = done_ff;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_erase_start;
    start_ok & is_erase;
  endsequence
  sequence s_erase_run;
    busy_ff & (st_ff == FWG_ST_ERASE);
  endsequence

  chk_por_hold: assert property (supply_low |=> !ready_ff && !latch_ff && !busy_ff && cnt_ff == 20'h00000)
    else $error("logic not held in reset while supply low");
  chk_puw_wait: assert property ($rose(ready_ff) |-> $past(cnt_ff) == 20'(PUW_CYC - 1))
    else $error("ready before power-up delay");
  chk_pu_latch: assert property ($rose(ready_ff) |-> !latch_ff && !busy_ff)
    else $error("latch set at end of power-up");
  chk_inhibit_start: assert property (supply_low && cmd_go |=> !busy_ff && !latch_ff)
    else $error("write acted on below inhibit level");
  chk_erase_bound: assert property (s_erase_run |-> cnt_ff < 20'(ERASE_CYC))
    else $error("erase longer than bound");
  chk_erase_begin: assert property (s_erase_start ##1 !supply_low |-> s_erase_run and (cnt_ff == 20'h00000))
    else $error("erase not started on accept");
  chk_prog_bound: assert property (st_ff == FWG_ST_PROGRAM |-> busy_ff && cnt_ff < 20'(PROG_CYC))
    else $error("program longer than bound");
  chk_sector_block: assert property (cmd_go && standby && (is_sect || is_prog) && !sect_ok |=> !busy_ff)
    else $error("protected sector written");
  chk_map_order: assert property (wr_go && sel_prot_lo && prot_wr_ok |=> prot_ff[7:0] == $past(pwdata[7:0]))
    else $error("protection byte misplaced");
  chk_latch_end: assert property (busy_ff && !supply_low && cnt_ff == 20'(ERASE_CYC - 1) && st_ff == FWG_ST_ERASE
                                  |=> !latch_ff && !busy_ff && done_ff)
    else $error("latch not cleared after erase");
  chk_busy_refuse: assert property (busy_ff && cmd_go && !supply_low && cnt_ff < 20'(PROG_CYC - 1)
                                    |=> busy_ff && refused_ff && cnt_ff == $past(cnt_ff) + 20'h00001)
    else $error("write accepted while busy");
endmodule
`default_nettype wire

// [sim/fwg_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module fwg_host_model import fwg_pkg::*; (
  input wire logic sys_clk,
  input wire logic dev_ready,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic supply_low
);
  // host starts deselected with supply good
  initial begin
    {psel, penable, pwrite, paddr, pwdata, supply_low} = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    // released lines other than pwrite must not keep the last value
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // write-type commands wait out the power-up delay unless forced early
  task automatic hold_off(input logic early);
    while (!early && dev_ready !== 1'b1) @(posedge sys_clk);
  endtask
  task automatic supply(input logic v);
    @(posedge sys_clk);
    supply_low <= v;
  endtask
endmodule
`default_nettype wire

// [sim/fwg_guard_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module fwg_guard_tb import fwg_pkg::*;;
  localparam int PUW = 20;
  localparam int ERA = 50;
  localparam int PRG = 30;
  logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, supply_low, e;
  logic busy, write_latch_flag, dev_ready, op_done;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [63:0] pm;
  int n_fail = 0, n_tests = 0, s, c, t0, ln;
  logic [23:0] ta;
  fwg_cmd_t op;
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  fwg_guard #(.NSECT(64), .PUW_CYC(PUW), .ERASE_CYC(ERA), .PROG_CYC(PRG)) fwg_guard_i (.sys_clk(sys_clk),
    .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_low(supply_low), .busy(busy),
    .write_latch_flag(write_latch_flag), .dev_ready(dev_ready), .op_done(op_done));
  fwg_host_model fwg_host_model_i (.sys_clk(sys_clk), .dev_ready(dev_ready), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .supply_low(supply_low));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    fwg_host_model_i.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a);
    fwg_host_model_i.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic cmd(input fwg_cmd_t o, input logic [23:0] a, input logic [2:0] bp, input logic early);
    fwg_host_model_i.hold_off(early);
    wr(FWG_OFF_ADDR, {8'h00, a});
    wr(FWG_OFF_CMD, {21'h0, bp, 5'h0, o});
  endtask
  function automatic logic [31:0] st(input logic b, l, y, i, f, input logic [2:0] bp);
    return {21'h0, bp, 3'h0, f, i, y, l, b};
  endfunction
  // busy cycles of the operation just launched land in c
  task automatic run_op();
    c = 0;
    @(posedge sys_clk);
    #1;
    while (busy === 1'b1 && c < 2000) begin
      @(posedge sys_clk);
      #1;
      c++;
    end
  endtask
  task automatic wready();
    while (dev_ready !== 1'b1 && $time - t0 < 20000) begin
      @(posedge sys_clk);
      #1;
    end
    c = ($time - t0) / 10;
  endtask
  initial begin
    #500_000;
    n_fail++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    void'($urandom(43));
    repeat (4) @(posedge sys_clk);
    check({28'h0, busy, write_latch_flag, dev_ready, op_done}, 32'h0);
    nrst <= 1'b1;
    t0 = $time;
    cmd(FWG_CMD_PERMIT, 24'h0, 3'h0, 1'b1);
    rd(FWG_OFF_STAT);
    check(r, st(0, 0, 0, 0, 0, 3'h0));
    wready();
    check(32'(c >= PUW - 1 && c <= PUW + 2), 32'h1);
    rd(FWG_OFF_STAT);
    check(r, st(0, 0, 1, 0, 0, 3'h0));
    rd(FWG_OFF_PROT_LO);
    check(r, 32'hFFFFFFFF);
    s = $urandom_range(63, 0);
    pm = ~(64'h1 << s);
    wr(FWG_OFF_PROT_LO, pm[31:0]);
    wr(FWG_OFF_PROT_HI, pm[63:32]);
    rd(FWG_OFF_PROT_HI);
    check(r, pm[63:32]);
    cmd(FWG_CMD_PERMIT, 24'h0, 3'h0, 1'b0);
    cmd(FWG_CMD_FORBID, 24'h0, 3'h0, 1'b0);
    // the latch updates on the edge that takes the command; look once it has settled
    #1;
    check({31'h0, write_latch_flag}, 32'h0);
    cmd(FWG_CMD_PERMIT, 24'h0, 3'h0, 1'b0);
    cmd(FWG_CMD_SECT_ERASE, 24'(s << 12), 3'h0, 1'b0);
    run_op();
    check(c, 0);
    rd(FWG_OFF_STAT);
    check(r, st(0, 1, 1, 0, 1, 3'h0));
    for (int k = 0; k < 3; k++) begin
      op = (k == 0) ? FWG_CMD_SECT_ERASE : (k == 1) ? FWG_CMD_PROGRAM : FWG_CMD_BLOCK_ERASE;
      ta = (k == 2) ? 24'(((s >> 4) ^ 1) << 16) : 24'((s ^ 1) << 12);
      ln = (k == 1) ? PRG : ERA;
      cmd(FWG_CMD_PERMIT, 24'h0, 3'h0, 1'b0);
      cmd(op, ta, 3'h0, 1'b0);
      run_op();
      check(32'(c >= ln - 1 && c <= ln + 1), 32'h1);
      check({31'h0, op_done}, 32'h1);
      rd(FWG_OFF_STAT);
      check(r, st(0, 0, 1, 0, 0, 3'h0));
    end
    cmd(FWG_CMD_PERMIT, 24'h0, 3'h0, 1'b0);
    cmd(FWG_CMD_SECT_ERASE, 24'((s ^ 1) << 12), 3'h0, 1'b0);
    cmd(FWG_CMD_PERMIT, 24'h0, 3'h0, 1'b1);
    check({31'h0, busy}, 32'h1);
    run_op();
    rd(FWG_OFF_STAT);
    check(r, st(0, 0, 1, 0, 1, 3'h0));
    cmd(FWG_CMD_PERMIT, 24'h0, 3'h0, 1'b0);
    cmd(FWG_CMD_STATUS_WR, 24'h0, 3'h7, 1'b0);
    repeat (3) @(posedge sys_clk);
    rd(FWG_OFF_STAT);
    check(r, st(0, 0, 1, 0, 0, 3'h7));
    cmd(FWG_CMD_PERMIT, 24'h0, 3'h0, 1'b0);
    cmd(FWG_CMD_SECT_ERASE, 24'((s ^ 1) << 12), 3'h0, 1'b0);
    run_op();
    check(32'(c >= ERA - 1 && c <= ERA + 1), 32'h1);
    cmd(FWG_CMD_PERMIT, 24'h0, 3'h0, 1'b0);
    cmd(FWG_CMD_CHIP_ERASE, 24'h0, 3'h0, 1'b0);
    run_op();
    check(c, 0);
    cmd(FWG_CMD_PERMIT, 24'h0, 3'h0, 1'b0);
    fwg_host_model_i.supply(1'b1);
    cmd(FWG_CMD_PERMIT, 24'h0, 3'h0, 1'b1);
    rd(FWG_OFF_STAT);
    check(r, st(0, 0, 0, 1, 0, 3'h0));
    fwg_host_model_i.supply(1'b0);
    t0 = $time;
    wready();
    check(32'(c >= PUW - 1 && c <= PUW + 2), 32'h1);
    rd(FWG_OFF_PROT_HI);
    check(r, pm[63:32]);
    rd(8'h0C);
    check(r, 32'h0);
    check({31'h0, e}, 32'h1);
    test_done();
  end
endmodule
`default_nettype wire
